// *** src/atf_top.sv ***
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "atf_consts.svh"

module atf_top
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rcOsc,
    input wire logic [9:0] convResult,
    output logic sampleEn,
    output logic convertEn,
    output logic convBusy
);
    atf_core_if core ();

    logic [7:0] ctrlTiming_r;
    logic [7:0] resHigh_r;
    logic [7:0] resLow_r;
    logic goDone_r;
    atf_pkg::atf_state_t state_r;
    logic [4:0] tadCnt_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic sampleEn_r;
    logic convertEn_r;

    logic setupPh;
    logic wrDone;
    logic [2:0] acqSel;
    logic [4:0] acqTads;
    logic lastTad;
    logic convEnd;

    // address decode, shared by error flagging and the unmapped access assertion
    function automatic logic atf_mapped(input logic [11:0] addr);
        atf_mapped = (addr == `ATF_OFF_CTRL_TIMING) || (addr == `ATF_OFF_RES_HIGH) ||
                     (addr == `ATF_OFF_RES_LOW) || (addr == `ATF_OFF_CONV_CTRL);
    endfunction : atf_mapped

    atf_tad_gen u_tad_gen
    (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .rcOsc(rcOsc),
        .core(core.tad_gen)
    );

    atf_result_fmt u_result_fmt
    (
        .core(core.fmt)
    );

    assign core.clkSel = ctrlTiming_r[`ATF_CS_MSB:`ATF_CS_LSB];
    assign core.raw = convResult;
    assign core.leftJust = ~ctrlTiming_r[`ATF_FMT_BIT];

    assign acqSel = ctrlTiming_r[`ATF_ACQ_MSB:`ATF_ACQ_LSB];
    assign acqTads = atf_pkg::atf_acq_tads(acqSel);
    assign lastTad = core.tick && (tadCnt_r == 5'h01);
    assign convEnd = ce && (state_r == atf_pkg::ST_CONV) && lastTad;

    // apb phases: the slave answers in the first access cycle
    assign setupPh = psel && !penable;
    assign wrDone = ce && psel && penable && pready_r && pwrite && !pslverr_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else if (ce)
        begin
            pready_r <= setupPh;
            pslverr_r <= setupPh && !atf_mapped(paddr);
        end
    end

    // read data is captured in the setup cycle; reserved bits read as zero
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prdata_r <= 32'h0000_0000;
        else if (ce && setupPh)
        begin
            case (paddr)
                `ATF_OFF_CTRL_TIMING: prdata_r <= {24'h00_0000, ctrlTiming_r};
                `ATF_OFF_RES_HIGH: prdata_r <= {24'h00_0000, resHigh_r};
                `ATF_OFF_RES_LOW: prdata_r <= {24'h00_0000, resLow_r};
                `ATF_OFF_CONV_CTRL: prdata_r <= {31'h0000_0000, goDone_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // timing control register; bit 6 is not stored
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ctrlTiming_r <= `ATF_CTRL_TIMING_RST;
        else if (wrDone && paddr == `ATF_OFF_CTRL_TIMING)
            ctrlTiming_r <= pwdata[7:0] & `ATF_CTRL_TIMING_MASK;
    end

    // result bytes: a finishing conversion overrides a software write
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resHigh_r <= `ATF_RESULT_RST;
            resLow_r <= `ATF_RESULT_RST;
        end
        else if (convEnd)
        begin
            resHigh_r <= core.hiByte;
            resLow_r <= core.loByte;
        end
        else if (wrDone)
        begin
            if (paddr == `ATF_OFF_RES_HIGH)
                resHigh_r <= pwdata[7:0];
            if (paddr == `ATF_OFF_RES_LOW)
                resLow_r <= pwdata[7:0];
        end
    end

    // start/done: software sets it, the end of conversion clears it;
    // a set in the same cycle as the clear wins and starts a new conversion
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            goDone_r <= 1'b0;
        else if (wrDone && paddr == `ATF_OFF_CONV_CTRL && pwdata[`ATF_GO_BIT])
            goDone_r <= 1'b1;
        else if (convEnd)
            goDone_r <= 1'b0;
    end

    // conversion sequencer, counting conversion clock periods in tadCnt_r
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= atf_pkg::ST_IDLE;
            tadCnt_r <= 5'h00;
        end
        else if (ce)
        begin
            case (state_r)
                atf_pkg::ST_IDLE:
                    if (goDone_r)
                    begin
                        if (core.isRc)
                        begin
                            // rc clock is asynchronous, so the wait runs up to the next rc tick first
                            state_r <= atf_pkg::ST_RC_WAIT;
                            tadCnt_r <= 5'h01;
                        end
                        else if (core.tick && acqTads != 5'h00)
                        begin
                            // fosc start waits for a prescaler tick, so no counted period is cut short
                            state_r <= atf_pkg::ST_ACQ;
                            tadCnt_r <= acqTads;
                        end
                        else if (core.tick)
                        begin
                            state_r <= atf_pkg::ST_CONV;
                            tadCnt_r <= `ATF_CONV_TADS;
                        end
                    end
                atf_pkg::ST_RC_WAIT:
                    if (lastTad)
                    begin
                        if (acqTads != 5'h00)
                        begin
                            state_r <= atf_pkg::ST_ACQ;
                            tadCnt_r <= acqTads;
                        end
                        else
                        begin
                            state_r <= atf_pkg::ST_CONV;
                            tadCnt_r <= `ATF_CONV_TADS;
                        end
                    end
                atf_pkg::ST_ACQ:
                    if (lastTad)
                    begin
                        state_r <= atf_pkg::ST_CONV;
                        tadCnt_r <= `ATF_CONV_TADS;
                    end
                    else if (core.tick)
                        tadCnt_r <= tadCnt_r - 5'h01;
                atf_pkg::ST_CONV:
                    if (lastTad)
                    begin
                        state_r <= atf_pkg::ST_IDLE;
                        tadCnt_r <= 5'h00;
                    end
                    else if (core.tick)
                        tadCnt_r <= tadCnt_r - 5'h01;
                default:
                begin
                    state_r <= atf_pkg::ST_IDLE;
                    tadCnt_r <= 5'h00;
                end
            endcase
        end
    end

    // front end strobes follow the sequencer state one cycle later
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sampleEn_r <= 1'b0;
            convertEn_r <= 1'b0;
        end
        else if (ce)
        begin
            sampleEn_r <= (state_r == atf_pkg::ST_ACQ);
            convertEn_r <= (state_r == atf_pkg::ST_CONV);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sampleEn = sampleEn_r;
    assign convertEn = convertEn_r;
    assign convBusy = goDone_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_unmapped;
        ce && setupPh && !atf_mapped(paddr) |=> pslverr_r && pready_r;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

    sequence s_rc_start;
        ce && state_r == atf_pkg::ST_IDLE && goDone_r && core.isRc;
    endsequence
    sequence s_rc_hold;
        state_r == atf_pkg::ST_RC_WAIT && tadCnt_r == 5'h01;
    endsequence
    property p_rc_delay;
        s_rc_start |=> s_rc_hold;
    endproperty
    a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");

    property p_acq_entry;
        state_r != atf_pkg::ST_ACQ ##1 state_r == atf_pkg::ST_ACQ
            |-> tadCnt_r == atf_pkg::atf_acq_tads($past(acqSel));
    endproperty
    a_acq_entry: assert property (p_acq_entry) else $error("acquisition length wrong");

    sequence s_acq_last;
        ce && state_r == atf_pkg::ST_ACQ && lastTad;
    endsequence
    property p_acq_to_conv;
        s_acq_last |=> state_r == atf_pkg::ST_CONV && tadCnt_r == `ATF_CONV_TADS ##1 convertEn_r;
    endproperty
    a_acq_to_conv: assert property (p_acq_to_conv) else $error("conversion not started");

    property p_left_high;
        convEnd && ctrlTiming_r[`ATF_FMT_BIT] == 1'b0 |=> resHigh_r == $past(convResult[9:2]) && !goDone_r;
    endproperty
    a_left_high: assert property (p_left_high) else $error("left high byte wrong");

    property p_left_low;
        convEnd && ctrlTiming_r[`ATF_FMT_BIT] == 1'b0 |=> resLow_r[7:6] == $past(convResult[1:0]);
    endproperty
    a_left_low: assert property (p_left_low) else $error("left low byte wrong");

    property p_right_high;
        convEnd && ctrlTiming_r[`ATF_FMT_BIT] |=> resHigh_r == {6'h00, $past(convResult[9:8])};
    endproperty
    a_right_high: assert property (p_right_high) else $error("right high byte wrong");

    property p_right_low;
        convEnd && ctrlTiming_r[`ATF_FMT_BIT] |=> resLow_r == $past(convResult[7:0]);
    endproperty
    a_right_low: assert property (p_right_low) else $error("right low byte wrong");
endmodule : atf_top

`default_nettype wire

// *** common/atf_consts.svh ***
`ifndef ATF_CONSTS_SVH
`define ATF_CONSTS_SVH

// register byte addresses on the apb bus
`define ATF_OFF_CTRL_TIMING 12'h000
`define ATF_OFF_RES_HIGH 12'h004
`define ATF_OFF_RES_LOW 12'h008
`define ATF_OFF_CONV_CTRL 12'h00c

// field positions in adc_control_timing
`define ATF_FMT_BIT 7
`define ATF_ACQ_MSB 5
`define ATF_ACQ_LSB 3
`define ATF_CS_MSB 2
`define ATF_CS_LSB 0
// bit 6 is unimplemented and reads as zero
`define ATF_CTRL_TIMING_MASK 8'hbf
`define ATF_CTRL_TIMING_RST 8'h00
`define ATF_RESULT_RST 8'h00

// start/done bit in the conversion control register
`define ATF_GO_BIT 0

// conversion clock periods spent converting ten bits
`define ATF_CONV_TADS 5'h0b

// rc oscillator and system clock rates
`define ATF_RC_FREQ_KHZ 600
`define ATF_CLK_FREQ_KHZ 200000
`define ATF_RC_PERIOD_CYC (`ATF_CLK_FREQ_KHZ / `ATF_RC_FREQ_KHZ)

`endif

// *** common/atf_pkg.sv ***
package atf_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_RC_WAIT, ST_ACQ, ST_CONV} atf_state_t;

    // system clock divisor for a clock select code, zero for the rc codes
    function automatic logic [6:0] atf_div(input logic [2:0] sel);
        case (sel)
            3'h0: atf_div = 7'h02;
            3'h1: atf_div = 7'h08;
            3'h2: atf_div = 7'h20;
            3'h4: atf_div = 7'h04;
            3'h5: atf_div = 7'h10;
            3'h6: atf_div = 7'h40;
            default: atf_div = 7'h00;
        endcase
    endfunction : atf_div

    function automatic logic atf_is_rc(input logic [2:0] sel);
        atf_is_rc = (sel[1:0] == 2'h3);
    endfunction : atf_is_rc

    // automatic acquisition length in conversion clock periods
    function automatic logic [4:0] atf_acq_tads(input logic [2:0] sel);
        case (sel)
            3'h0: atf_acq_tads = 5'h00;
            3'h1: atf_acq_tads = 5'h02;
            3'h2: atf_acq_tads = 5'h04;
            3'h3: atf_acq_tads = 5'h06;
            3'h4: atf_acq_tads = 5'h08;
            3'h5: atf_acq_tads = 5'h0c;
            3'h6: atf_acq_tads = 5'h10;
            default: atf_acq_tads = 5'h14;
        endcase
    endfunction : atf_acq_tads

endpackage : atf_pkg

// *** common/atf_core_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface atf_core_if;
    logic [2:0] clkSel;
    logic tick;
    logic isRc;
    logic [9:0] raw;
    logic leftJust;
    logic [7:0] hiByte;
    logic [7:0] loByte;

    modport tad_gen (input clkSel, output tick, output isRc);
    modport fmt (input raw, input leftJust, output hiByte, output loByte);
    modport core (output clkSel, output raw, output leftJust, input tick, input isRc, input hiByte, input loByte);
endinterface : atf_core_if

`default_nettype wire

// *** src/atf_tad_gen.sv ***
`timescale 1ns/10ps
`default_nettype none

module atf_tad_gen
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic rcOsc,
    atf_core_if.tad_gen core
);
    logic rcMeta_r;
    logic rcSync_r;
    logic rcPrev_r;
    logic [6:0] divCnt_r;
    logic [6:0] divisor;
    logic rcRise;
    logic divHit;

    // the rc oscillator is a free running pin, so it is synchronised first
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rcMeta_r <= 1'b0;
            rcSync_r <= 1'b0;
            rcPrev_r <= 1'b0;
        end
        else if (ce)
        begin
            rcMeta_r <= rcOsc;
            rcSync_r <= rcMeta_r;
            rcPrev_r <= rcSync_r;
        end
    end

    assign divisor = atf_pkg::atf_div(core.clkSel);
    assign rcRise = rcSync_r & ~rcPrev_r;
    // >= so a change to a faster divisor never strands the counter
    assign divHit = (divCnt_r >= divisor - 7'h01);

    // system clock prescaler
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            divCnt_r <= 7'h00;
        else if (ce)
            divCnt_r <= divHit ? 7'h00 : divCnt_r + 7'h01;
    end

    assign core.isRc = atf_pkg::atf_is_rc(core.clkSel);
    // one conversion clock period ends on each tick
    assign core.tick = ce & (core.isRc ? rcRise : divHit);

    // helper: clock cycles since the last tick with an unchanged select
    logic [6:0] sinceTick_r;
    logic selSame_r;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sinceTick_r <= 7'h00;
            selSame_r <= 1'b0;
        end
        else if (ce)
        begin
            sinceTick_r <= core.tick ? 7'h00 : sinceTick_r + 7'h01;
            selSame_r <= core.tick;
            if (!core.tick && $changed(core.clkSel))
                selSame_r <= 1'b0;
            else if (!core.tick)
                selSame_r <= selSame_r;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_div_spacing;
        core.tick && !core.isRc && selSame_r && $stable(core.clkSel) |-> sinceTick_r == divisor - 7'h01;
    endproperty
    a_div_spacing: assert property (p_div_spacing) else $error("prescaled tick spacing wrong");

    property p_rc_source;
        core.tick && core.isRc && $past(ce) && $past(ce, 2) && $past(ce, 3) |-> $past(rcOsc, 2) && !$past(rcOsc, 3);
    endproperty
    a_rc_source: assert property (p_rc_source) else $error("rc tick without rc edge");
endmodule : atf_tad_gen

`default_nettype wire

// *** src/atf_result_fmt.sv ***
`timescale 1ns/10ps
`default_nettype none

module atf_result_fmt
(
    atf_core_if.fmt core
);
    // reserved bits are driven as zero so a read never shows stale data
    always_comb
    begin
        if (core.leftJust)
        begin
            core.hiByte = core.raw[9:2];
            core.loByte = {core.raw[1:0], 6'h00};
        end
        else
        begin
            core.hiByte = {6'h00, core.raw[9:8]};
            core.loByte = core.raw[7:0];
        end
    end
endmodule : atf_result_fmt

`default_nettype wire

// *** tb/atf_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "atf_consts.svh"

module atf_top_bench;
    // acquisition lengths in tads and fosc divisors, by select code
    localparam int ACQ_T[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    localparam int DIV_T[8] = '{2, 8, 32, 0, 4, 16, 64, 0};

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rcOsc = 1'b0;
    logic rcPrev = 1'b0;
    logic [9:0] convResult = 10'h000;
    logic sampleEn;
    logic convertEn;
    logic convBusy;
    int rcCnt = 0;
    int miscompares = 0;
    int compares = 0;

    always #2.5 clock = ~clock;

    // free-running rc source; slow enough that each tad spans hundreds of system cycles
    always @(posedge clock)
    begin
        rcCnt <= (rcCnt >= `ATF_RC_PERIOD_CYC - 1) ? 0 : rcCnt + 1;
        rcOsc <= (rcCnt < `ATF_RC_PERIOD_CYC / 2);
    end

    // clock enable is dropped once, in test_freeze
    atf_top atf_top_i (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rcOsc(rcOsc),
        .convResult(convResult),
        .sampleEn(sampleEn),
        .convertEn(convertEn),
        .convBusy(convBusy)
    );

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic hang(input string name);
        miscompares++;
        $display("[FAIL] %s expected done seen timeout", name);
        tally_and_finish();
    endtask : hang

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
            hang("apb ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] addr, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, {24'h000000, d}, rd, err);
    endtask : wr

    task automatic rdchk(input string name, input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h00000000, rd, err);
        chk(name, exp, rd);
    endtask : rdchk

    // reset values, the unimplemented control bit, writable result and an unmapped slot
    task automatic test_regs();
        logic [31:0] rd;
        logic err;
        chk("busy at reset", 32'h00000000, {31'h0, convBusy});
        rdchk("ctrl reset", `ATF_OFF_CTRL_TIMING, 32'h00000000);
        rdchk("high reset", `ATF_OFF_RES_HIGH, 32'h00000000);
        rdchk("low reset", `ATF_OFF_RES_LOW, 32'h00000000);
        rdchk("go reset", `ATF_OFF_CONV_CTRL, 32'h00000000);
        wr(`ATF_OFF_CTRL_TIMING, 8'hff);
        rdchk("ctrl mask", `ATF_OFF_CTRL_TIMING, 32'h000000bf);
        wr(`ATF_OFF_RES_HIGH, 8'ha5);
        rdchk("high write", `ATF_OFF_RES_HIGH, 32'h000000a5);
        apb(1'b0, 12'h010, 32'h00000000, rd, err);
        chk("unmapped read err", 32'h00000001, {31'h0, err});
        chk("unmapped read data", 32'h00000000, rd);
        apb(1'b1, 12'h010, 32'h000000ff, rd, err);
        chk("unmapped write err", 32'h00000001, {31'h0, err});
    endtask : test_regs

    // clock enable low: a setup cycle must not be answered while frozen
    task automatic test_freeze();
        @(posedge clock);
        ce <= 1'b0;
        psel <= 1'b1;
        paddr <= `ATF_OFF_CTRL_TIMING;
        repeat (4) @(posedge clock);
        #1;
        chk("pready while frozen", 32'h00000000, {31'h0, pready});
        @(posedge clock);
        psel <= 1'b0;
        ce <= 1'b1;
        rdchk("ctrl after freeze", `ATF_OFF_CTRL_TIMING, 32'h000000bf);
    endtask : test_freeze

    // one conversion with clock code, acq code and format all taken from code
    task automatic conv_case(input logic [2:0] code);
        logic [9:0] res;
        logic [7:0] expHi;
        logic [7:0] expLo;
        logic rise;
        logic seen;
        int cyc;
        int n;
        int nAcq;
        int nConv;
        int ePre;
        int eAcq;
        int eConv;
        res = 10'h1a5 + {code, 7'h3b};
        seen = 1'b0;
        nAcq = 0;
        nConv = 0;
        ePre = 0;
        eAcq = 0;
        eConv = 0;
        wr(`ATF_OFF_CTRL_TIMING, {code[0], 1'b0, code, code});
        convResult <= res;
        // start well clear of an rc edge so the start delay counts exactly one edge
        if (DIV_T[code] == 0)
        begin
            for (n = 0; n < 1000; n++)
            begin
                @(posedge clock);
                #1;
                if (rcOsc && !rcPrev)
                    break;
                rcPrev = rcOsc;
            end
            if (n == 1000)
                hang("rc edge");
            rcPrev = rcOsc;
            repeat (10) @(posedge clock);
        end
        wr(`ATF_OFF_CONV_CTRL, 8'h01);
        for (cyc = 0; cyc < 20000; cyc++)
        begin
            @(posedge clock);
            #1;
            rise = rcOsc && !rcPrev;
            rcPrev = rcOsc;
            if (cyc == 0)
                chk("busy after go", 32'h00000001, {31'h0, convBusy});
            if (rise && !seen)
                ePre++;
            if (rise && sampleEn === 1'b1)
                eAcq++;
            if (rise && convertEn === 1'b1)
                eConv++;
            if (sampleEn === 1'b1)
                nAcq++;
            if (convertEn === 1'b1)
                nConv++;
            if (sampleEn === 1'b1 || convertEn === 1'b1)
                seen = 1'b1;
            if (convBusy === 1'b0)
                break;
        end
        if (cyc == 20000)
            hang("conversion done");
        if (DIV_T[code] == 0)
        begin
            chk("rc start delay edges", 32'd1, ePre);
            chk("rc acq edges", ACQ_T[code], eAcq);
            chk("rc conv edges", 32'd11, eConv);
        end
        else
        begin
            chk("acq cycles", ACQ_T[code] * DIV_T[code], nAcq);
            chk("conv cycles", 11 * DIV_T[code], nConv);
        end
        if (code[0])
        begin
            expHi = {6'h00, res[9:8]};
            expLo = res[7:0];
        end
        else
        begin
            expHi = res[9:2];
            expLo = {res[1:0], 6'h00};
        end
        rdchk("result high", `ATF_OFF_RES_HIGH, {24'h000000, expHi});
        rdchk("result low", `ATF_OFF_RES_LOW, {24'h000000, expLo});
        rdchk("go cleared", `ATF_OFF_CONV_CTRL, 32'h00000000);
    endtask : conv_case

    // main sequence
    initial
    begin
        int c;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        test_regs();
        test_freeze();
        for (c = 0; c < 8; c++)
            conv_case(c[2:0]);
        tally_and_finish();
    end
endmodule : atf_top_bench

`default_nettype wire
